/* File: dbgtp_pkg.sv */
package dbgtp_pkg;
  localparam int IR_W = 5;
  localparam logic [4:0] IR_EXTEST = 5'h00;
  localparam logic [4:0] IR_IDCODE = 5'h01;
  localparam logic [4:0] IR_SAMPLE = 5'h02;
  localparam logic [4:0] IR_IMPL = 5'h03;
  localparam logic [4:0] IR_INTEST = 5'h04;
  localparam logic [4:0] IR_HIZ = 5'h05;
  localparam logic [4:0] IR_CLAMP = 5'h06;
  localparam logic [4:0] IR_BYP_LO = 5'h07;
  localparam logic [4:0] IR_ADDR = 5'h08;
  localparam logic [4:0] IR_DATA = 5'h09;
  localparam logic [4:0] IR_CTRL = 5'h0a;
  localparam logic [4:0] IR_ALL = 5'h0b;
  localparam logic [4:0] IR_TRACE = 5'h10;
  localparam logic [4:0] IR_BYPASS = 5'h1f;
  localparam logic [4:0] IR_CAPTURE = 5'h01;
  localparam int CTRL_BREAK_STATUS_FLAG = 3;
  localparam int CTRL_BRKREQ = 12;
  localparam int DBG_DBP = 1;
  localparam int DBG_PROBE_BREAK_INPUT = 5;
  localparam int DBG_DM = 30;
  localparam int DBG_DBD = 31;
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] FN_SWBRK = 6'h3f;
  localparam logic [5:0] FN_SWBRK_OLD = 6'h0e;
  localparam logic [31:0] DRET_WORD = 32'h4200_001f;
  localparam logic [31:0] ADDR_SCRATCH = 32'h0fff_e210;
  localparam logic [31:0] ADDR_CFG = 32'h0fff_e214;
  localparam logic [31:0] ADDR_STAT = 32'h0fff_e218;
  localparam logic [7:0] CFG_DIV_RST = 8'h04;
  localparam logic [5:0] TRC_BITS = 6'h20;
  typedef enum logic [3:0] {
    T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR, T_PA_DR, T_EX2_DR,
    T_UP_DR, T_SEL_IR, T_CAP_IR, T_SH_IR, T_EX1_IR, T_PA_IR, T_EX2_IR, T_UP_IR
  } dbgtp_tap_t;
endpackage

/* File: dbgtp_tap.sv */
`timescale 1ns/10ps
module dbgtp_tap (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step,
  input wire logic tms,
  output dbgtp_pkg::dbgtp_tap_t state_r
);
  dbgtp_pkg::dbgtp_tap_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      dbgtp_pkg::T_RESET: state_nxt = tms ? dbgtp_pkg::T_RESET : dbgtp_pkg::T_IDLE;
      dbgtp_pkg::T_IDLE: state_nxt = tms ? dbgtp_pkg::T_SEL_DR : dbgtp_pkg::T_IDLE;
      dbgtp_pkg::T_SEL_DR: state_nxt = tms ? dbgtp_pkg::T_SEL_IR : dbgtp_pkg::T_CAP_DR;
      dbgtp_pkg::T_CAP_DR: state_nxt = tms ? dbgtp_pkg::T_EX1_DR : dbgtp_pkg::T_SH_DR;
      dbgtp_pkg::T_SH_DR: state_nxt = tms ? dbgtp_pkg::T_EX1_DR : dbgtp_pkg::T_SH_DR;
      dbgtp_pkg::T_EX1_DR: state_nxt = tms ? dbgtp_pkg::T_UP_DR : dbgtp_pkg::T_PA_DR;
      dbgtp_pkg::T_PA_DR: state_nxt = tms ? dbgtp_pkg::T_EX2_DR : dbgtp_pkg::T_PA_DR;
      dbgtp_pkg::T_EX2_DR: state_nxt = tms ? dbgtp_pkg::T_UP_DR : dbgtp_pkg::T_SH_DR;
      dbgtp_pkg::T_UP_DR: state_nxt = tms ? dbgtp_pkg::T_SEL_DR : dbgtp_pkg::T_IDLE;
      dbgtp_pkg::T_SEL_IR: state_nxt = tms ? dbgtp_pkg::T_RESET : dbgtp_pkg::T_CAP_IR;
      dbgtp_pkg::T_CAP_IR: state_nxt = tms ? dbgtp_pkg::T_EX1_IR : dbgtp_pkg::T_SH_IR;
      dbgtp_pkg::T_SH_IR: state_nxt = tms ? dbgtp_pkg::T_EX1_IR : dbgtp_pkg::T_SH_IR;
      dbgtp_pkg::T_EX1_IR: state_nxt = tms ? dbgtp_pkg::T_UP_IR : dbgtp_pkg::T_PA_IR;
      dbgtp_pkg::T_PA_IR: state_nxt = tms ? dbgtp_pkg::T_EX2_IR : dbgtp_pkg::T_PA_IR;
      dbgtp_pkg::T_EX2_IR: state_nxt = tms ? dbgtp_pkg::T_UP_IR : dbgtp_pkg::T_SH_IR;
      dbgtp_pkg::T_UP_IR: state_nxt = tms ? dbgtp_pkg::T_SEL_DR : dbgtp_pkg::T_IDLE;
      default: state_nxt = dbgtp_pkg::T_RESET;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= dbgtp_pkg::T_RESET;
    else if (step)
      state_r <= state_nxt;
  end
endmodule

/* File: dbgtp_top.sv */
`timescale 1ns/10ps
module dbgtp_top #(
  parameter int BSR_LEN = 16,
  parameter logic [31:0] DBG_VECTOR = 32'hff20_0200,
  parameter logic [31:0] IMPL_VAL = 32'h0000_0001,
  parameter logic [31:0] ID_VAL = 32'h1234_5671 // arbitrary id value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  input wire logic [BSR_LEN-1:0] pin_in,
  input wire logic [BSR_LEN-1:0] core_pin_out,
  input wire logic [BSR_LEN-1:0] core_result,
  output logic [BSR_LEN-1:0] pin_out,
  output logic [BSR_LEN-1:0] pin_oe_n,
  output logic [BSR_LEN-1:0] core_stim,
  output logic core_test,
  input wire logic [31:0] addr_capture,
  input wire logic [31:0] data_capture,
  output logic [31:0] addr_update,
  output logic [31:0] data_update,
  input wire logic trace_pc_valid,
  input wire logic [31:0] trace_pc,
  input wire logic [2:0] trace_status,
  output logic [2:0] trace_status_pins,
  output logic debug_clock,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] instr_pc,
  input wire logic instr_in_slot,
  input wire logic [31:0] slot_branch_pc,
  input wire logic cp0_usable,
  input wire logic coprocessor_move_write,
  input wire logic [31:0] move_wdata,
  output logic pc_redirect,
  output logic [31:0] pc_target,
  output logic cop_unusable_exc,
  output logic debug_mode_flag,
  output logic exc_mask,
  output logic [31:0] debug_reg,
  output logic [31:0] debug_return_address
);
  if (BSR_LEN < 2) $error("scan chain too short");

  function automatic logic is_swbrk(input logic [31:0] w);
    return w[31:26] == dbgtp_pkg::OP_SPECIAL &&
      (w[5:0] == dbgtp_pkg::FN_SWBRK || w[5:0] == dbgtp_pkg::FN_SWBRK_OLD);
  endfunction

  // pin synchronisers
  logic tck_s1_r, tck_s2_r, tck_d_r, tms_s1_r, tms_s2_r, tdi_s1_r, tdi_s2_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {tck_s1_r, tck_s2_r, tck_d_r} <= 3'h0;
      {tms_s1_r, tms_s2_r, tdi_s1_r, tdi_s2_r} <= 4'hf;
    end
    else
    begin
      tck_s1_r <= tck;
      tck_s2_r <= tck_s1_r;
      tck_d_r <= tck_s2_r;
      tms_s1_r <= tms;
      tms_s2_r <= tms_s1_r;
      tdi_s1_r <= tdi;
      tdi_s2_r <= tdi_s1_r;
    end
  end
  logic rise, fall;
  assign rise = tck_s2_r & ~tck_d_r;
  assign fall = ~tck_s2_r & tck_d_r;

  dbgtp_pkg::dbgtp_tap_t st;
  dbgtp_tap u_tap (
    .pclk(pclk),
    .presetn(presetn),
    .step(rise),
    .tms(tms_s2_r),
    .state_r(st)
  );

  logic cap, shf, upd, trace_r, trace_go, dm_r, brkreq_r;
  assign cap = rise && st == dbgtp_pkg::T_CAP_DR;
  assign shf = rise && st == dbgtp_pkg::T_SH_DR;
  assign upd = rise && st == dbgtp_pkg::T_UP_DR;

  // instruction register
  logic [4:0] ir_r, ir_sh_r;
  assign trace_go = ir_r == dbgtp_pkg::IR_TRACE && st == dbgtp_pkg::T_IDLE;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ir_r <= dbgtp_pkg::IR_BYPASS;
      ir_sh_r <= dbgtp_pkg::IR_CAPTURE;
    end
    else if (trace_go)
      ir_r <= dbgtp_pkg::IR_BYPASS;
    else if (rise)
    begin
      if (st == dbgtp_pkg::T_RESET)
        ir_r <= dbgtp_pkg::IR_BYPASS;
      else if (st == dbgtp_pkg::T_CAP_IR)
        ir_sh_r <= dbgtp_pkg::IR_CAPTURE;
      else if (st == dbgtp_pkg::T_SH_IR)
        ir_sh_r <= {tdi_s2_r, ir_sh_r[4:1]};
      else if (st == dbgtp_pkg::T_UP_IR)
        ir_r <= ir_sh_r;
    end
  end

  logic sel_bsr, sel_addr, sel_data, sel_ctrl, sel_all, sel_const, drive_bsr;
  assign sel_bsr = ir_r == dbgtp_pkg::IR_EXTEST || ir_r == dbgtp_pkg::IR_SAMPLE || ir_r == dbgtp_pkg::IR_INTEST;
  assign sel_all = ir_r == dbgtp_pkg::IR_ALL;
  assign sel_addr = ir_r == dbgtp_pkg::IR_ADDR || sel_all;
  assign sel_data = ir_r == dbgtp_pkg::IR_DATA || sel_all;
  assign sel_ctrl = ir_r == dbgtp_pkg::IR_CTRL || sel_all;
  assign sel_const = ir_r == dbgtp_pkg::IR_IDCODE || ir_r == dbgtp_pkg::IR_IMPL;
  assign drive_bsr = ir_r == dbgtp_pkg::IR_EXTEST || ir_r == dbgtp_pkg::IR_CLAMP;

  // bypass stage and fixed-value registers
  logic byp_r;
  logic [31:0] cst_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      byp_r <= 1'b0;
      cst_r <= 32'h0;
    end
    else if (cap)
    begin
      byp_r <= 1'b0;
      cst_r <= ir_r == dbgtp_pkg::IR_IMPL ? IMPL_VAL : ID_VAL;
    end
    else if (shf)
    begin
      byp_r <= tdi_s2_r;
      cst_r <= {tdi_s2_r, cst_r[31:1]};
    end
  end

  // boundary scan chain
  logic [BSR_LEN-1:0] bsr_r, bsr_upd_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bsr_r <= '0;
      bsr_upd_r <= '0;
    end
    else if (sel_bsr && cap)
      bsr_r <= ir_r == dbgtp_pkg::IR_INTEST ? core_result : pin_in;
    else if (sel_bsr && shf)
      bsr_r <= {tdi_s2_r, bsr_r[BSR_LEN-1:1]};
    else if (sel_bsr && upd)
      bsr_upd_r <= bsr_r;
  end

  // probe address, data and control paths
  logic [31:0] addr_sh_r, data_sh_r, ctrl_sh_r, ctrl_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_sh_r <= 32'h0;
      data_sh_r <= 32'h0;
      ctrl_sh_r <= 32'h0;
    end
    else if (cap)
    begin
      if (sel_addr)
        addr_sh_r <= addr_capture;
      if (sel_data)
        data_sh_r <= data_capture;
      if (sel_ctrl)
        ctrl_sh_r <= ctrl_r;
    end
    else if (shf)
    begin
      if (sel_addr)
        addr_sh_r <= {sel_all ? data_sh_r[0] : tdi_s2_r, addr_sh_r[31:1]};
      if (sel_data)
        data_sh_r <= {sel_all ? ctrl_sh_r[0] : tdi_s2_r, data_sh_r[31:1]};
      if (sel_ctrl)
        ctrl_sh_r <= {tdi_s2_r, ctrl_sh_r[31:1]};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_update <= 32'h0;
      data_update <= 32'h0;
    end
    else if (upd)
    begin
      if (sel_addr)
        addr_update <= addr_sh_r;
      if (sel_data)
        data_update <= data_sh_r;
    end
  end

  // control register, break status mirrors debug mode
  logic brk_in;
  assign brk_in = trace_r && !tdi_s2_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= 32'h0;
    else
    begin
      if (upd && sel_ctrl)
        ctrl_r <= ctrl_sh_r;
      ctrl_r[dbgtp_pkg::CTRL_BREAK_STATUS_FLAG] <= dm_r;
      if (brk_in || (upd && sel_ctrl && ctrl_sh_r[dbgtp_pkg::CTRL_BRKREQ]))
        ctrl_r[dbgtp_pkg::CTRL_BRKREQ] <= 1'b1;
    end
  end
  assign brkreq_r = ctrl_r[dbgtp_pkg::CTRL_BRKREQ];

  // pin control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= '0;
      pin_oe_n <= '1;
      core_stim <= '0;
      core_test <= 1'b0;
    end
    else
    begin
      pin_out <= drive_bsr ? bsr_upd_r : core_pin_out;
      pin_oe_n <= ir_r == dbgtp_pkg::IR_HIZ ? '1 : '0;
      core_stim <= bsr_upd_r;
      core_test <= ir_r == dbgtp_pkg::IR_INTEST;
    end
  end

  // debug clock divider, software sets the rate
  logic [7:0] cfg_div_r, div_cnt_r;
  logic debug_clock_en;
  assign debug_clock_en = div_cnt_r == 8'h0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_r <= 8'h0;
      debug_clock <= 1'b0;
    end
    else
    begin
      div_cnt_r <= debug_clock_en ? cfg_div_r : div_cnt_r - 8'h1;
      if (debug_clock_en)
        debug_clock <= ~debug_clock;
    end
  end

  // real-time trace
  logic [31:0] trc_sh_r;
  logic dbg_exc;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trace_r <= 1'b0;
      trc_sh_r <= 32'h0;
      trace_status_pins <= 3'h0;
    end
    else
    begin
      if (trace_go)
        trace_r <= 1'b1;
      else if (brk_in || dbg_exc)
        trace_r <= 1'b0;
      if (trace_r && trace_pc_valid)
        trc_sh_r <= trace_pc;
      else if (trace_r && debug_clock_en && debug_clock)
      begin
        trc_sh_r <= {1'b0, trc_sh_r[31:1]};
        trace_status_pins <= trace_status;
      end
    end
  end

  // serial output changes on falling test clock, trace on debug clock
  logic tdo_bit;
  always_comb
  begin
    tdo_bit = byp_r;
    if (st == dbgtp_pkg::T_SH_IR)
      tdo_bit = ir_sh_r[0];
    else if (sel_addr)
      tdo_bit = addr_sh_r[0];
    else if (sel_data)
      tdo_bit = data_sh_r[0];
    else if (sel_ctrl)
      tdo_bit = ctrl_sh_r[0];
    else if (sel_bsr)
      tdo_bit = bsr_r[0];
    else if (sel_const)
      tdo_bit = cst_r[0];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end
    else if (trace_r)
    begin
      tdo <= trc_sh_r[0];
      tdo_oe_n <= 1'b0;
    end
    else if (fall)
    begin
      tdo <= tdo_bit;
      tdo_oe_n <= !(st == dbgtp_pkg::T_SH_DR || st == dbgtp_pkg::T_SH_IR);
    end
  end

  // debug exceptions and return
  logic brk_take, jtag_take, debug_return_instr_hit, debug_return_instr_pend_r, slot_done, dbd_r, dbp_r, probe_break_input_r;
  assign brk_take = instr_valid && !debug_return_instr_pend_r && is_swbrk(instr_word) && !dm_r;
  assign jtag_take = brkreq_r && !dm_r && !brk_take;
  assign dbg_exc = brk_take || jtag_take;
  assign debug_return_instr_hit = instr_valid && !debug_return_instr_pend_r && instr_word == dbgtp_pkg::DRET_WORD;
  assign slot_done = debug_return_instr_pend_r && instr_valid;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dm_r <= 1'b0;
      exc_mask <= 1'b0;
      debug_return_instr_pend_r <= 1'b0;
      {dbd_r, dbp_r, probe_break_input_r} <= 3'h0;
      pc_redirect <= 1'b0;
      pc_target <= 32'h0;
      cop_unusable_exc <= 1'b0;
    end
    else
    begin
      pc_redirect <= 1'b0;
      cop_unusable_exc <= debug_return_instr_hit && !cp0_usable;
      if (debug_return_instr_hit && cp0_usable)
        debug_return_instr_pend_r <= 1'b1;
      if (dbg_exc)
      begin
        dm_r <= 1'b1;
        exc_mask <= 1'b1;
        dbd_r <= brk_take && instr_in_slot;
        dbp_r <= brk_take;
        probe_break_input_r <= jtag_take;
        pc_redirect <= 1'b1;
        pc_target <= DBG_VECTOR;
      end
      else if (slot_done)
      begin
        debug_return_instr_pend_r <= 1'b0;
        dm_r <= 1'b0;
        exc_mask <= 1'b0;
        pc_redirect <= 1'b1;
        pc_target <= debug_return_address;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      debug_return_address <= 32'h0;
    else if (brk_take)
      debug_return_address <= instr_in_slot ? slot_branch_pc : instr_pc;
    else if (coprocessor_move_write)
      debug_return_address <= move_wdata;
  end

  always_comb
  begin
    debug_reg = 32'h0;
    debug_reg[dbgtp_pkg::DBG_DBD] = dbd_r;
    debug_reg[dbgtp_pkg::DBG_DM] = dm_r;
    debug_reg[dbgtp_pkg::DBG_PROBE_BREAK_INPUT] = probe_break_input_r;
    debug_reg[dbgtp_pkg::DBG_DBP] = dbp_r;
  end
  assign debug_mode_flag = dm_r;

  // apb slave, answers one cycle into the access phase
  logic [31:0] scratch_r;
  logic acc;
  assign acc = psel && penable && !pready;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
      scratch_r <= 32'h0;
      cfg_div_r <= dbgtp_pkg::CFG_DIV_RST;
    end
    else
    begin
      pready <= acc;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (acc)
      begin
        case (paddr)
          dbgtp_pkg::ADDR_SCRATCH:
          begin
            prdata <= scratch_r;
            if (pwrite)
              scratch_r <= pwdata;
          end
          dbgtp_pkg::ADDR_CFG:
          begin
            prdata <= {24'h0, cfg_div_r};
            if (pwrite)
              cfg_div_r <= pwdata[7:0];
          end
          dbgtp_pkg::ADDR_STAT: prdata <= {28'h0, debug_return_instr_pend_r, trace_r, brkreq_r, dm_r};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_brk;
    instr_valid && !debug_return_instr_pend_r && is_swbrk(instr_word) && !dm_r;
  endsequence
  sequence s_entered;
    dm_r && pc_redirect && pc_target == DBG_VECTOR;
  endsequence
  trace_reload_a: assert property (trace_go |=> ir_r == dbgtp_pkg::IR_BYPASS && trace_r)
    else $error("trace entry did not reload bypass");
  brk_enter_a: assert property (s_brk |=> s_entered)
    else $error("breakpoint did not enter debug mode");
  brk_nop_a: assert property (dm_r && !slot_done |=> dm_r)
    else $error("debug mode lost without return");
  debug_return_instr_slot_a: assert property (debug_return_instr_hit && cp0_usable && !dbg_exc |=> !pc_redirect && dm_r == $past(dm_r))
    else $error("debug return did not wait for slot");
  debug_return_instr_ret_a: assert property (slot_done && !dbg_exc |=> !dm_r && pc_target == $past(debug_return_address))
    else $error("debug return wrong target or flag");
  break_status_flag_copy_a: assert property (##1 ctrl_r[dbgtp_pkg::CTRL_BREAK_STATUS_FLAG] == $past(dm_r))
    else $error("break status not a copy of debug mode");
  cop_unusable_a: assert property (debug_return_instr_hit && !cp0_usable |=> cop_unusable_exc && !debug_return_instr_pend_r)
    else $error("missing coprocessor unusable");
  hiz_pins_a: assert property (ir_r == dbgtp_pkg::IR_HIZ |=> pin_oe_n == '1)
    else $error("pins not floated");
  clamp_pins_a: assert property (ir_r == dbgtp_pkg::IR_CLAMP |=> pin_out == $past(bsr_upd_r))
    else $error("clamp not driving scan data");
  addr_update_a: assert property (upd && ir_r == dbgtp_pkg::IR_ADDR |=> addr_update == $past(addr_sh_r))
    else $error("address not transferred");
  trace_break_a: assert property (trace_r && !tdi_s2_r |=> !trace_r && brkreq_r)
    else $error("break input ignored in trace");
  mask_dm_a: assert property (exc_mask == dm_r)
    else $error("mask differs from debug mode");
endmodule

/* File: dbgtp_top_end.sv */
`timescale 1ns/10ps

/* File: dbgtp_probe.sv */
`timescale 1ns/10ps
// probe model: tck stands low between frames
module dbgtp_probe (
  input wire logic pclk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial
  begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end
  // one 80 ns tck period, tdo taken mid high phase
  task automatic tick(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge pclk);
    tck <= 1'h1;
    repeat (2) @(posedge pclk);
    o = tdo;
    repeat (2) @(posedge pclk);
    tck <= 1'h0;
  endtask
  // instruction load, always ends in run-test/idle
  task automatic ir(input logic [4:0] c);
    logic o;
    @(posedge pclk);
    tick(1'h1, 1'h1, o);
    tick(1'h1, 1'h1, o);
    tick(1'h0, 1'h1, o);
    tick(1'h0, 1'h1, o);
    for (int i = 0; i < 5; i++)
      tick(i == 4, c[i], o);
    tick(1'h1, 1'h1, o);
    tick(1'h0, 1'h1, o);
    tdi <= 1'h1;
    @(posedge pclk);
  endtask
  // data scan of n bits, lsb first
  task automatic dr(input int n, input logic [31:0] d, output logic [31:0] q);
    logic o;
    q = '0;
    @(posedge pclk);
    tick(1'h1, 1'h1, o);
    tick(1'h0, 1'h1, o);
    tick(1'h0, 1'h1, o);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, d[i], o);
      q[i] = o;
    end
    tick(1'h1, 1'h1, o);
    tick(1'h0, 1'h1, o);
    tdi <= 1'h1;
    @(posedge pclk);
  endtask
  // break pulse on serial input
  task automatic brk();
    @(posedge pclk);
    tdi <= 1'h0;
    repeat (8) @(posedge pclk);
    tdi <= 1'h1;
  endtask
endmodule

/* File: dbgtp_top_tb.sv */
`timescale 1ns/10ps
module dbgtp_top_tb;
  localparam logic [31:0] DV = 32'hff20_0200;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tck, tms, tdi, tdo, tdo_oe_n, core_test, er;
  logic [31:0] paddr, pwdata, prdata, addr_capture, data_capture, addr_update, data_update, trace_pc, instr_word;
  logic [31:0] instr_pc;
  logic [31:0] slot_branch_pc, move_wdata, pc_target, debug_reg, debug_return_address, rd, v, ret;
  logic [15:0] pin_in, core_pin_out, core_result, pin_oe_n, pin_out;
  logic [2:0] trace_status, trace_status_pins;
  logic [5:0] fn;
  logic trace_pc_valid, instr_valid, instr_in_slot, cp0_usable, coprocessor_move_write;
  logic pc_redirect, cop_unusable_exc, debug_mode_flag, exc_mask;
  logic [4:0] byp [4] = '{5'h07, 5'h1f, 5'h15, 5'h06};
  int fails, n_tests;
  dbgtp_top #(.DBG_VECTOR(DV)) i_dbgtp_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .tck, .tms, .tdi, .tdo, .tdo_oe_n, .pin_in, .core_pin_out, .core_result, .pin_out,
    .pin_oe_n, .core_stim(), .core_test, .addr_capture, .data_capture, .addr_update, .data_update,
    .trace_pc_valid, .trace_pc, .trace_status, .trace_status_pins, .debug_clock(), .instr_valid, .instr_word,
    .instr_pc, .instr_in_slot, .slot_branch_pc, .cp0_usable, .coprocessor_move_write, .move_wdata, .pc_redirect,
    .pc_target, .cop_unusable_exc, .debug_mode_flag, .exc_mask, .debug_reg, .debug_return_address);
  dbgtp_probe i_dbgtp_probe (.pclk, .tdo, .tck, .tms, .tdi);
  initial
  begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic cpu(input logic [31:0] w, input logic [31:0] pc, input logic s, input logic u);
    @(posedge pclk);
    instr_valid <= 1'h1;
    instr_word <= w;
    instr_pc <= pc;
    instr_in_slot <= s;
    cp0_usable <= u;
    @(posedge pclk);
    instr_valid <= 1'h0;
    #1;
  endtask
  initial
  begin
    #500000;
    fails++;
    tally_and_finish();
  end
  initial
  begin
    {psel, penable, pwrite, trace_pc_valid, instr_valid, instr_in_slot, coprocessor_move_write} = '0;
    {paddr, pwdata, addr_capture, data_capture, trace_pc, instr_word, instr_pc, move_wdata} = '0;
    {pin_in, core_pin_out, core_result, trace_status} = '0;
    cp0_usable = 1'h1;
    slot_branch_pc = 32'h0000_0ff8;
    presetn = 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    i_dbgtp_probe.tick(1'h0, 1'h1, er);
    apb(1'h1, dbgtp_pkg::ADDR_SCRATCH, 32'h5a5a_0ff0);
    apb(1'h0, dbgtp_pkg::ADDR_SCRATCH, 32'h0);
    chk("scratch", 32'h5a5a_0ff0, rd);
    apb(1'h0, 32'h0fff_e300, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    i_dbgtp_probe.ir(dbgtp_pkg::IR_SAMPLE);
    i_dbgtp_probe.dr(16, 32'h9c3a, v);
    foreach (byp[i])
    begin
      i_dbgtp_probe.ir(byp[i]);
      i_dbgtp_probe.dr(8, 32'hb4, v);
      chk("bypass", 32'h68, v);
    end
    chk("clamp_pins", 32'h9c3a, 32'(pin_out));
    i_dbgtp_probe.ir(dbgtp_pkg::IR_HIZ);
    chk("hiz", 32'hffff, 32'(pin_oe_n));
    core_result <= 16'h5af0;
    i_dbgtp_probe.ir(dbgtp_pkg::IR_INTEST);
    chk("core_test", 32'h1, 32'(core_test));
    i_dbgtp_probe.dr(16, 32'h0, v);
    chk("intest", 32'h5af0, v);
    i_dbgtp_probe.ir(dbgtp_pkg::IR_ADDR);
    i_dbgtp_probe.dr(32, 32'h1357_9bdf, v);
    chk("addr_update", 32'h1357_9bdf, addr_update);
    data_capture <= 32'hcafe_0042;
    i_dbgtp_probe.ir(dbgtp_pkg::IR_DATA);
    i_dbgtp_probe.dr(32, 32'h0bad_f00d, v);
    chk("data_shift", 32'hcafe_0042, v);
    chk("data_update", 32'h0bad_f00d, data_update);
    addr_capture <= 32'h0000_a5c3;
    i_dbgtp_probe.ir(dbgtp_pkg::IR_ALL);
    i_dbgtp_probe.dr(32, 32'h0, v);
    chk("all_shift", 32'h0000_a5c3, v);
    for (int j = 0; j < 2; j++)
    begin
      fn = (j == 1) ? dbgtp_pkg::FN_SWBRK_OLD : dbgtp_pkg::FN_SWBRK;
      ret = (j == 1) ? 32'h0000_0ff8 : 32'h0000_1000;
      cpu({dbgtp_pkg::OP_SPECIAL, 20'h0, fn}, 32'h0000_1000, j == 1, 1'h1);
      chk("redirect", 32'h1, 32'(pc_redirect));
      chk("target", DV, pc_target);
      chk("mode", 32'h3, {30'h0, exc_mask, debug_mode_flag});
      chk("return_addr", ret, debug_return_address);
      chk("cause", 32'h1, 32'(debug_reg[dbgtp_pkg::DBG_DBP]));
      i_dbgtp_probe.ir(dbgtp_pkg::IR_CTRL);
      i_dbgtp_probe.dr(32, 32'h0, v);
      chk("brk_status", 32'h1, 32'(v[dbgtp_pkg::CTRL_BREAK_STATUS_FLAG]));
      cpu({dbgtp_pkg::OP_SPECIAL, 20'h0, fn}, 32'h0000_2000, 1'h0, 1'h1);
      chk("nop_brk", 32'h0, 32'(pc_redirect));
      cpu(dbgtp_pkg::DRET_WORD, 32'h0000_2004, 1'h0, 1'h0);
      chk("cop_unusable", 32'h1, 32'(cop_unusable_exc));
      if (j == 1)
      begin
        @(posedge pclk);
        coprocessor_move_write <= 1'h1;
        move_wdata <= 32'h0000_2468;
        @(posedge pclk);
        coprocessor_move_write <= 1'h0;
        cpu(32'h0, 32'h0000_3000, 1'h0, 1'h1);
        cpu(32'h0, 32'h0000_3004, 1'h0, 1'h1);
        ret = 32'h0000_2468;
      end
      cpu(dbgtp_pkg::DRET_WORD, 32'h0000_3008, 1'h0, 1'h1);
      chk("slot_wait", 32'h0, 32'(pc_redirect));
      cpu(32'h0, 32'h0000_300c, 1'h0, 1'h1);
      chk("ret_redirect", 32'h1, 32'(pc_redirect));
      chk("ret_target", ret, pc_target);
      chk("mode_clear", 32'h0, 32'(debug_mode_flag));
      i_dbgtp_probe.dr(32, 32'h0, v);
      chk("brk_clear", 32'h0, 32'(v[dbgtp_pkg::CTRL_BREAK_STATUS_FLAG]));
    end
    trace_status <= 3'h5;
    i_dbgtp_probe.ir(dbgtp_pkg::IR_TRACE);
    @(posedge pclk);
    trace_pc_valid <= 1'h1;
    trace_pc <= 32'h0000_4000;
    @(posedge pclk);
    trace_pc_valid <= 1'h0;
    repeat (12) @(posedge pclk);
    apb(1'h0, dbgtp_pkg::ADDR_STAT, 32'h0);
    chk("trace_on", 32'h4, rd & 32'h4);
    chk("tdo_drive", 32'h0, 32'(tdo_oe_n));
    chk("trace_pins", 32'h5, 32'(trace_status_pins));
    i_dbgtp_probe.brk();
    apb(1'h0, dbgtp_pkg::ADDR_STAT, 32'h0);
    chk("break_stat", 32'h3, rd & 32'h7);
    chk("probe_cause", 32'h1, 32'(debug_reg[dbgtp_pkg::DBG_PROBE_BREAK_INPUT]));
    i_dbgtp_probe.dr(8, 32'hb4, v);
    chk("ir_bypass", 32'h68, v);
    tally_and_finish();
  end
endmodule
